/* verilog/sbrp_pkg.sv */
package sbrp_pkg;
    // ==========================================
    // Bus widths and configuration register
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam logic [15:0] CFG_ADDR = 16'hF221;
    localparam int RM_BIT = 15;
    localparam int BRL_LSB = 12;
    localparam int BL_LSB = 9;
    localparam logic RM_RESET = 1'b0;
    localparam logic [2:0] BRL_RESET = 3'h4;
    localparam logic [2:0] BRL_MIN = 3'h3;
    localparam logic [2:0] BRL_MAX = 3'h7;
    localparam logic [2:0] BL_RESET = 3'h0;
    localparam logic [2:0] BL_CONT = 3'h0;
    localparam logic [2:0] BL_MAX = 3'h4;
    localparam logic [15:0] ADDR_STEP = 16'h0001;
    localparam logic [15:0] WRAP_NONE = 16'hFFFF;

    // ==========================================
    // Regions where clocked reads are allowed
    localparam logic [15:0] SYNC_BUF_LO = 16'h0200;
    localparam logic [15:0] SYNC_BUF_HI = 16'h03FF;
    localparam logic [15:0] SYNC_REG_LO = 16'hF000;

    // ==========================================
    // Timing
    localparam int CORE_PERIOD_NS = 40;
    localparam int LINK_PERIOD_NS = 320;
    localparam int LINK_HALF_CYCLES = LINK_PERIOD_NS / (2 * CORE_PERIOD_NS);
    localparam int BRL3_MIN_PERIOD_NS = 25;
    localparam int SYNC_W = 38;
endpackage

/* verilog/sbrp_if.sv */
`timescale 1ns/10ps
interface sbrp_if;
    logic link_clk;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic address_valid_strobe_n;
    logic reset_pin_n;
    logic [15:0] addr;
    logic [15:0] dq_host_out;
    logic dq_host_oe;
    logic [15:0] dq_dev_out;
    logic dq_dev_oe;
    logic rdy;
    wire [15:0] dq;

    // ==========================================
    // Shared data wire, resolved from both enables
    // Undriven it shows the inverse of the device word, so a late sample cannot pass by luck
    assign dq = dq_host_oe ? dq_host_out : (dq_dev_oe ? dq_dev_out : ~dq_dev_out);

    modport dev (
        input link_clk, ce_n, oe_n, we_n, address_valid_strobe_n, reset_pin_n, addr, dq,
        output dq_dev_out, dq_dev_oe, rdy
    );
    modport host (
        output link_clk, ce_n, oe_n, we_n, address_valid_strobe_n, reset_pin_n, addr,
        output dq_host_out, dq_host_oe,
        input dq, rdy
    );
endinterface

/* verilog/sbrp_device.sv */
`timescale 1ns/10ps
module sbrp_device (
    input logic i_core_clk,
    input logic i_sys_rst,
    sbrp_if.dev link,
    output logic [15:0] o_mem_addr,
    input logic [15:0] i_mem_rdata,
    output logic o_read_mode,
    output logic [2:0] o_latency,
    output logic [2:0] o_burst_len,
    output logic o_burst_active
);
    typedef enum logic [1:0] {
        D_IDLE,
        D_LATENCY,
        D_STREAM
    } sbrp_dev_state_type;

    // ==========================================
    // Pin synchroniser
    logic [sbrp_pkg::SYNC_W-1:0] pin_raw;
    logic [sbrp_pkg::SYNC_W-1:0] meta_reg;
    logic [sbrp_pkg::SYNC_W-1:0] pin_reg;
    logic clk_s;
    logic ce_n_s;
    logic oe_n_s;
    logic we_n_s;
    logic avd_n_s;
    logic rp_n_s;
    logic [15:0] addr_s;
    logic [15:0] dq_s;
    logic clk_prev_reg;
    logic we_prev_reg;

    assign pin_raw = {link.link_clk, link.ce_n, link.oe_n, link.we_n,
                      link.address_valid_strobe_n, link.reset_pin_n, link.addr, link.dq};

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            meta_reg <= {sbrp_pkg::SYNC_W{1'b1}};
            pin_reg <= {sbrp_pkg::SYNC_W{1'b1}};
        end else begin
            meta_reg <= pin_raw;
            pin_reg <= meta_reg;
        end
    end

    assign clk_s = pin_reg[37];
    assign ce_n_s = pin_reg[36];
    assign oe_n_s = pin_reg[35];
    assign we_n_s = pin_reg[34];
    assign avd_n_s = pin_reg[33];
    assign rp_n_s = pin_reg[32];
    assign addr_s = pin_reg[31:16];
    assign dq_s = pin_reg[15:0];

    // Edges are found on the second stage only, never on the metastable one
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            clk_prev_reg <= 1'b1;
            we_prev_reg <= 1'b1;
        end else begin
            clk_prev_reg <= clk_s;
            we_prev_reg <= we_n_s;
        end
    end

    // ==========================================
    // Decodes
    logic clk_rise;
    logic we_rise;
    logic abort;
    logic latch_hit;
    logic async_hit;
    logic cfg_hit;
    logic hw_reset;
    logic rm_reg;
    logic [2:0] brl_reg;
    logic [2:0] bl_reg;

    assign clk_rise = clk_s & ~clk_prev_reg;
    assign we_rise = we_n_s & ~we_prev_reg;
    assign hw_reset = ~rp_n_s;
    assign abort = ce_n_s | hw_reset | ~we_n_s;
    assign latch_hit = clk_rise & ~avd_n_s & ~ce_n_s & we_n_s;
    assign async_hit = ~rm_reg & ~avd_n_s & ~ce_n_s & we_n_s;
    assign cfg_hit = we_rise & ~ce_n_s & (addr_s == sbrp_pkg::CFG_ADDR);

    // ==========================================
    // Configuration: read mode, latency, burst length

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || hw_reset) begin
            rm_reg <= sbrp_pkg::RM_RESET;
            brl_reg <= sbrp_pkg::BRL_RESET;
            bl_reg <= sbrp_pkg::BL_RESET;
        end else if (cfg_hit) begin
            rm_reg <= dq_s[sbrp_pkg::RM_BIT];
            brl_reg <= dq_s[sbrp_pkg::BRL_LSB +: 3];
            bl_reg <= dq_s[sbrp_pkg::BL_LSB +: 3];
        end
    end

    // ==========================================
    // Burst engine
    sbrp_dev_state_type state_reg;
    logic [15:0] addr_reg;
    logic [2:0] cnt_reg;
    logic [2:0] blen_reg;
    logic sync_reg;
    logic rdy_reg;
    logic valid_reg;
    logic [15:0] wrap_mask;
    logic [15:0] addr_next;
    logic lat_done;

    // Codes above the largest length behave as continuous
    assign wrap_mask = (blen_reg == sbrp_pkg::BL_CONT || blen_reg > sbrp_pkg::BL_MAX) ?
                       sbrp_pkg::WRAP_NONE :
                       (sbrp_pkg::ADDR_STEP << (blen_reg + 3'h1)) - sbrp_pkg::ADDR_STEP;
    assign addr_next = (addr_reg & ~wrap_mask) |
                       ((addr_reg + sbrp_pkg::ADDR_STEP) & wrap_mask);
    assign lat_done = cnt_reg <= 3'h1;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || abort) begin
            state_reg <= D_IDLE;
        end else if (latch_hit) begin
            state_reg <= D_LATENCY;
        end else if (clk_rise) begin
            unique case (state_reg)
                D_IDLE: state_reg <= D_IDLE;
                D_LATENCY: state_reg <= lat_done ? D_STREAM : D_LATENCY;
                D_STREAM: state_reg <= D_STREAM;
            endcase
        end
    end

    // Settings are snapshotted at the latch edge, so a write mid-burst waits
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            cnt_reg <= sbrp_pkg::BRL_RESET;
            blen_reg <= sbrp_pkg::BL_RESET;
            sync_reg <= sbrp_pkg::RM_RESET;
        end else if (latch_hit) begin
            cnt_reg <= brl_reg;
            blen_reg <= bl_reg;
            sync_reg <= rm_reg;
        end else if (clk_rise && state_reg == D_LATENCY && !lat_done) begin
            cnt_reg <= cnt_reg - 3'h1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            addr_reg <= 16'h0000;
        end else if (latch_hit || async_hit) begin
            addr_reg <= addr_s;
        end else if (clk_rise && state_reg == D_STREAM && sync_reg) begin
            addr_reg <= addr_next;
        end
    end

    // A clocked access in async mode still fetches the first word, then holds it
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || abort) begin
            valid_reg <= 1'b0;
        end else if (latch_hit || async_hit) begin
            valid_reg <= 1'b1;
        end
    end

    // Ready stands from edge n until edge n+1, where the host takes word one
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || abort) begin
            rdy_reg <= 1'b0;
        end else if (clk_rise) begin
            rdy_reg <= (state_reg == D_LATENCY) && lat_done && !latch_hit;
        end
    end

    // ==========================================
    // Outputs
    logic [15:0] dout_reg;
    logic dq_oe_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            dout_reg <= 16'h0000;
            dq_oe_reg <= 1'b0;
        end else begin
            dout_reg <= i_mem_rdata;
            dq_oe_reg <= valid_reg & ~ce_n_s & ~oe_n_s & ~abort;
        end
    end

    assign o_mem_addr = addr_reg;
    assign link.dq_dev_out = dout_reg;
    assign link.dq_dev_oe = dq_oe_reg;
    assign link.rdy = rdy_reg;
    assign o_read_mode = rm_reg;
    assign o_latency = brl_reg;
    assign o_burst_len = bl_reg;
    assign o_burst_active = (state_reg != D_IDLE);
endmodule // sbrp_device

/* verilog/sbrp_host.sv */
`timescale 1ns/10ps
module sbrp_host #(
    parameter int LINK_HALF = sbrp_pkg::LINK_HALF_CYCLES
) (
    input logic i_core_clk,
    input logic i_sys_rst,
    sbrp_if.host link,
    input logic i_cfg_wr,
    input logic [15:0] i_cfg_data,
    input logic i_rd_start,
    input logic [15:0] i_rd_addr,
    input logic [5:0] i_rd_words,
    input logic i_hw_reset,
    output logic o_ready,
    output logic o_rd_refused,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid
);
    typedef enum logic [2:0] {
        H_IDLE,
        H_WR,
        H_WR_END,
        H_ADDR,
        H_WAIT,
        H_READ,
        H_STOP
    } sbrp_host_state_type;

    localparam int LINK_PERIOD = 2 * LINK_HALF * sbrp_pkg::CORE_PERIOD_NS;
    localparam logic FAST_LINK = LINK_PERIOD < sbrp_pkg::BRL3_MIN_PERIOD_NS;

    // ==========================================
    // Link clock divider; pins change on falls and are sampled on rises
    logic [7:0] div_reg;
    logic clk_reg;
    logic tick;
    logic rise;
    logic fall;

    assign tick = (div_reg == 8'(LINK_HALF - 1));
    assign rise = tick & ~clk_reg;
    assign fall = tick & clk_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            div_reg <= 8'h00;
            clk_reg <= 1'b0;
        end else begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
            clk_reg <= tick ? ~clk_reg : clk_reg;
        end
    end

    // ==========================================
    // Input synchroniser for ready and data
    logic [16:0] meta_reg;
    logic [16:0] in_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            meta_reg <= 17'h0_0000;
            in_reg <= 17'h0_0000;
        end else begin
            meta_reg <= {link.rdy, link.dq};
            in_reg <= meta_reg;
        end
    end

    // ==========================================
    // Request acceptance
    logic sync_ok;
    logic [15:0] cfg_fixed;
    logic brl_low;
    logic take_cfg;
    logic take_rd;

    assign sync_ok = (i_rd_addr >= sbrp_pkg::SYNC_BUF_LO && i_rd_addr <= sbrp_pkg::SYNC_BUF_HI) ||
                     (i_rd_addr >= sbrp_pkg::SYNC_REG_LO);
    // Three-cycle latency only on a slow link; otherwise fall back to default
    assign brl_low = (i_cfg_data[sbrp_pkg::BRL_LSB +: 3] < sbrp_pkg::BRL_MIN) ||
                     (FAST_LINK && i_cfg_data[sbrp_pkg::BRL_LSB +: 3] == sbrp_pkg::BRL_MIN);
    assign cfg_fixed = brl_low ? {i_cfg_data[15], sbrp_pkg::BRL_RESET, i_cfg_data[11:0]} :
                       i_cfg_data;
    assign take_cfg = o_ready & i_cfg_wr;
    assign take_rd = o_ready & ~i_cfg_wr & i_rd_start & sync_ok;

    // ==========================================
    // Access sequencer
    sbrp_host_state_type state_reg;
    logic pend_reg;
    logic pend_cfg_reg;
    logic [15:0] addr_reg;
    logic [15:0] wdata_reg;
    logic [5:0] left_reg;
    logic ce_n_reg;
    logic oe_n_reg;
    logic we_n_reg;
    logic avd_n_reg;
    logic dq_oe_reg;
    logic rp_n_reg;
    logic [15:0] rdata_reg;
    logic rvalid_reg;
    logic refused_reg;
    logic capture;

    assign capture = rise && ((state_reg == H_WAIT && in_reg[16]) || state_reg == H_READ);

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || i_hw_reset) begin
            pend_reg <= 1'b0;
            pend_cfg_reg <= 1'b0;
        end else if (take_cfg || take_rd) begin
            pend_reg <= 1'b1;
            pend_cfg_reg <= take_cfg;
        end else if (fall && state_reg == H_IDLE) begin
            pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || i_hw_reset) begin
            addr_reg <= 16'h0000;
            wdata_reg <= 16'h0000;
            left_reg <= 6'h00;
        end else if (take_cfg) begin
            addr_reg <= sbrp_pkg::CFG_ADDR;
            wdata_reg <= cfg_fixed;
        end else if (take_rd) begin
            addr_reg <= i_rd_addr;
            left_reg <= (i_rd_words == 6'h00) ? 6'h01 : i_rd_words;
        end else if (capture) begin
            left_reg <= left_reg - 6'h01;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst || i_hw_reset) begin
            state_reg <= H_IDLE;
            ce_n_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            avd_n_reg <= 1'b1;
            dq_oe_reg <= 1'b0;
        end else if (capture) begin
            state_reg <= (left_reg == 6'h01) ? H_STOP : H_READ;
        end else if (fall) begin
            unique case (state_reg)
                H_IDLE: begin
                    if (pend_reg) begin
                        state_reg <= pend_cfg_reg ? H_WR : H_ADDR;
                        ce_n_reg <= 1'b0;
                        we_n_reg <= ~pend_cfg_reg;
                        dq_oe_reg <= pend_cfg_reg;
                        oe_n_reg <= pend_cfg_reg;
                        avd_n_reg <= pend_cfg_reg;
                    end
                end
                H_WR: begin
                    state_reg <= H_WR_END;
                    we_n_reg <= 1'b1;
                end
                H_WR_END: begin
                    state_reg <= H_IDLE;
                    ce_n_reg <= 1'b1;
                    dq_oe_reg <= 1'b0;
                end
                H_ADDR: begin
                    state_reg <= H_WAIT;
                    avd_n_reg <= 1'b1;
                end
                H_WAIT: state_reg <= H_WAIT;
                H_READ: state_reg <= H_READ;
                H_STOP: begin
                    state_reg <= H_IDLE;
                    ce_n_reg <= 1'b1;
                    oe_n_reg <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            rdata_reg <= 16'h0000;
            rvalid_reg <= 1'b0;
            refused_reg <= 1'b0;
            rp_n_reg <= 1'b0;
        end else begin
            rdata_reg <= capture ? in_reg[15:0] : rdata_reg;
            rvalid_reg <= capture;
            refused_reg <= o_ready & ~i_cfg_wr & i_rd_start & ~sync_ok;
            rp_n_reg <= ~i_hw_reset;
        end
    end

    assign o_ready = (state_reg == H_IDLE) & ~pend_reg;
    assign o_rd_data = rdata_reg;
    assign o_rd_valid = rvalid_reg;
    assign o_rd_refused = refused_reg;
    assign link.link_clk = clk_reg;
    assign link.ce_n = ce_n_reg;
    assign link.oe_n = oe_n_reg;
    assign link.we_n = we_n_reg;
    assign link.address_valid_strobe_n = avd_n_reg;
    assign link.reset_pin_n = rp_n_reg;
    assign link.addr = addr_reg;
    assign link.dq_host_out = wdata_reg;
    assign link.dq_host_oe = dq_oe_reg;
endmodule // sbrp_host

/* tb/sbrp_chk.sv */
`timescale 1ns/10ps
module sbrp_chk (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic link_clk,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic address_valid_strobe_n,
    input wire logic reset_pin_n,
    input wire logic [15:0] addr,
    input wire logic [15:0] dq,
    input wire logic dq_host_oe,
    input wire logic [15:0] dq_dev_out,
    input wire logic dq_dev_oe,
    input wire logic rdy
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    // ==========================================
    // Shadow of the link, sampled by the core clock
    logic lk_q;
    logic we_q;
    logic sync_q;
    logic act_q;
    logic [2:0] lat_q;
    logic [3:0] cnt_q;
    wire lk_rise = link_clk && !lk_q;
    wire lk_fall = !link_clk && lk_q;
    wire latch = lk_rise && !address_valid_strobe_n && !ce_n && we_n;
    wire cfg_cap = we_n && !we_q && !ce_n && (addr == sbrp_pkg::CFG_ADDR);
    wire cnt_inc = lk_rise && (cnt_q != 4'hF);

    // Config is only written between bursts, so the shadow never moves mid-burst
    always_ff @(posedge i_core_clk) begin
        lk_q <= link_clk;
        we_q <= we_n;
        if (i_sys_rst || !reset_pin_n) begin
            sync_q <= sbrp_pkg::RM_RESET;
            lat_q <= sbrp_pkg::BRL_RESET;
        end else if (cfg_cap) begin
            sync_q <= dq[15];
            lat_q <= dq[14:12];
        end
        act_q <= !i_sys_rst && (latch || (act_q && !ce_n && reset_pin_n));
        cnt_q <= latch ? 4'h0 : cnt_q + {3'h0, cnt_inc};
    end

    // ==========================================
    // Ready pulse spans one link period
    sequence s_rdy_pulse;
        rdy [*8] ##1 !rdy;
    endsequence

    a_first_word_latency: assert property (lk_fall && act_q && sync_q |-> ##2 (rdy == (cnt_q == lat_q)))
        else $error("ready not at the latency count");
    a_ready_one_period: assert property ($rose(rdy) && sync_q |-> s_rdy_pulse)
        else $error("ready pulse length wrong");
    a_ready_in_burst: assert property ($rose(rdy) |-> !ce_n && !oe_n)
        else $error("ready outside a selected read");
    a_float_deselect: assert property ((ce_n || oe_n) [*4] |-> !dq_dev_oe)
        else $error("data driven while deselected");
    a_write_ends: assert property ((!we_n) [*4] |-> !dq_dev_oe && !rdy)
        else $error("write strobe did not end burst");
    a_pin_reset_ends: assert property ((!reset_pin_n) [*4] |-> !dq_dev_oe && !rdy)
        else $error("reset pin did not end burst");
    // Device sees the rise through two flops and an edge register, then loads the word
    a_data_on_rise: assert property (sync_q && dq_dev_oe && $past(dq_dev_oe) && $changed(dq_dev_out)
        |-> $past(lk_rise, 4))
        else $error("burst data changed away from a link rise");
    a_no_contention: assert property (!(dq_host_oe && dq_dev_oe))
        else $error("both ends drive data");
    c_ready: cover property ($rose(rdy));
endmodule // sbrp_chk

/* tb/sync_burst_read_port_tb_top.sv */
`timescale 1ns/10ps
module sync_burst_read_port_tb_top;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic cfg_wr = 1'b0;
    logic [15:0] cfg_data = 16'h0000;
    logic rd_start = 1'b0;
    logic [15:0] rd_addr = 16'h0000;
    logic [5:0] rd_words = 6'h00;
    logic hw_reset = 1'b0;
    logic ready, refused, rd_valid, read_mode, burst_active;
    logic [15:0] rd_data, mem_addr;
    logic [2:0] latency, burst_len;
    logic [15:0] bad_addr [5] = '{16'h0000, 16'h01FF, 16'h0400, 16'h8000, 16'h8010};
    int bad_count = 0;
    int n_compared = 0;
    // Bench memory: each word is its address scrambled, so a wrong address shows
    wire [15:0] mem_rdata = mem_addr ^ 16'h5A5A;

    always #20 i_core_clk = ~i_core_clk;

    // ==========================================
    // Both ends joined by the link
    sbrp_if link_if();
    sbrp_device sbrp_device_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .link(link_if),
        .o_mem_addr(mem_addr), .i_mem_rdata(mem_rdata), .o_read_mode(read_mode),
        .o_latency(latency), .o_burst_len(burst_len), .o_burst_active(burst_active));
    sbrp_host sbrp_host_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .link(link_if),
        .i_cfg_wr(cfg_wr), .i_cfg_data(cfg_data), .i_rd_start(rd_start), .i_rd_addr(rd_addr),
        .i_rd_words(rd_words), .i_hw_reset(hw_reset), .o_ready(ready),
        .o_rd_refused(refused), .o_rd_data(rd_data), .o_rd_valid(rd_valid));
    sbrp_chk sbrp_chk_i (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .link_clk(link_if.link_clk), .ce_n(link_if.ce_n), .oe_n(link_if.oe_n),
        .we_n(link_if.we_n), .address_valid_strobe_n(link_if.address_valid_strobe_n),
        .reset_pin_n(link_if.reset_pin_n), .addr(link_if.addr), .dq(link_if.dq),
        .dq_host_oe(link_if.dq_host_oe), .dq_dev_out(link_if.dq_dev_out),
        .dq_dev_oe(link_if.dq_dev_oe), .rdy(link_if.rdy));

    // ==========================================
    // Access tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge i_core_clk);
            #1;
            k++;
        end while (ready !== 1'b1 && k < 3000);
        check(16'(k < 3000), 16'h0001);
    endtask

    task automatic cfg(input logic [15:0] d);
        wait_ready();
        @(posedge i_core_clk);
        cfg_wr <= 1'b1;
        cfg_data <= d;
        @(posedge i_core_clk);
        cfg_wr <= 1'b0;
        @(posedge i_core_clk);
        wait_ready();
    endtask

    // Length 0 means continuous: plain increment that wraps only at 16 bits
    task automatic rd(input logic [15:0] a, input int n, input int len, input logic exp_ref);
        logic [15:0] e;
        logic ref_seen;
        int got;
        int k;
        got = 0;
        k = 0;
        ref_seen = 1'b0;
        wait_ready();
        @(posedge i_core_clk);
        rd_start <= 1'b1;
        rd_addr <= a;
        rd_words <= 6'(n);
        @(posedge i_core_clk);
        rd_start <= 1'b0;
        while (got < n && k < 3000) begin
            #1;
            if (rd_valid === 1'b1) begin
                e = (len == 0) ? a + 16'(got)
                    : ((a & ~16'(len - 1)) | ((a + 16'(got)) & 16'(len - 1)));
                check(rd_data, e ^ 16'h5A5A);
                got++;
            end
            if (refused === 1'b1) begin
                ref_seen = 1'b1;
                got = n;
            end
            k++;
            @(posedge i_core_clk);
        end
        check(16'(got), 16'(n));
        check({15'h0000, ref_seen}, {15'h0000, exp_ref});
    endtask

    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================
    // Tests
    initial begin
        repeat (20) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_core_clk);
        #1;
        check({9'h000, read_mode, latency, burst_len}, {9'h000, 1'b0, sbrp_pkg::BRL_RESET, 3'h0});
        rd(16'h0210, 1, 0, 1'b0);
        for (int l = 3; l <= 7; l++) begin
            cfg({1'b1, 3'(l), 3'h0, 9'h000});
            check({12'h000, read_mode, latency}, {12'h000, 1'b1, 3'(l)});
            rd(16'h0300, 3, 0, 1'b0);
        end
        for (int c = 1; c <= 4; c++) begin
            cfg({1'b1, 3'h4, 3'(c), 9'h000});
            check({13'h0000, burst_len}, {13'h0000, 3'(c)});
            rd(16'h0205, (4 << (c - 1)) + 1, 4 << (c - 1), 1'b0);
        end
        foreach (bad_addr[i]) rd(bad_addr[i], 1, 0, 1'b1);
        cfg({1'b1, 3'h3, 3'h0, 9'h000});
        rd(16'hFFFE, 4, 0, 1'b0);
        // Cold reset in mid-burst
        wait_ready();
        @(posedge i_core_clk);
        rd_start <= 1'b1;
        rd_addr <= 16'h0300;
        rd_words <= 6'h14;
        @(posedge i_core_clk);
        rd_start <= 1'b0;
        for (int k = 0; k < 2000 && rd_valid !== 1'b1; k++) @(posedge i_core_clk);
        repeat (16) @(posedge i_core_clk);
        check({15'h0000, burst_active}, 16'h0001);
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        #1;
        check({14'h0000, burst_active, link_if.dq_dev_oe}, 16'h0000);
        cfg({1'b1, 3'h5, 3'h2, 9'h000});
        @(posedge i_core_clk);
        hw_reset <= 1'b1;
        repeat (12) @(posedge i_core_clk);
        hw_reset <= 1'b0;
        repeat (12) @(posedge i_core_clk);
        #1;
        check({9'h000, read_mode, latency, burst_len}, {9'h000, 1'b0, 3'h4, 3'h0});
        rd(16'h0211, 1, 0, 1'b0);
        conclude();
    end

    // Whole run is a few thousand cycles; this bound only catches a hang
    initial begin
        repeat (20000) @(posedge i_core_clk);
        bad_count++;
        conclude();
    end
endmodule // sync_burst_read_port_tb_top
